/* serial_port_pkg.sv */
// constants for the dual serial register port
package serial_port_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam logic [5:0] TARGET_ID_HIGH = 6'h2E;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] SPI_DATA_START = 4'h8;
  localparam logic [3:0] SPI_BIT_DIR = 4'h0;
  localparam logic [3:0] SPI_BIT_INC = 4'h1;
  localparam logic [6:0] INDEX_RESET = 7'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_INDEX, I2C_WRITE, I2C_WACK, I2C_READ,
    I2C_RACK} i2c_state_t;
endpackage

/* edge_sync.sv */
// two-flop synchroniser with edge detection
`timescale 1ns/1ps
module edge_sync
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  logic meta_d;
  logic sync_d;
  logic last_d;

  always_comb
  begin
    meta_d = pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule

/* dual_serial_register_port.sv */
// I2C target and 3/4-wire SPI target sharing pads, giving register access
`timescale 1ns/1ps
module dual_serial_register_port
  import serial_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cs_pin,
  input wire logic sclk_pin,
  input wire logic serial_in_pin_in,
  output logic serial_in_pin_out,
  output logic serial_in_pin_oe,
  input wire logic serial_out_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe,
  input wire logic three_wire_select,
  output logic [6:0] reg_index,
  input wire logic [7:0] reg_read_data,
  output logic [7:0] reg_write_data,
  output logic reg_write_strobe,
  output logic reg_read_strobe,
  output logic bus_busy
);
  import serial_port_pkg::*;

  logic cs_lvl, cs_rise, cs_fall;
  logic clk_lvl, clk_rise, clk_fall;
  logic dat_lvl, dat_rise, dat_fall;
  logic sel_lvl;
  logic sel_meta_q, sel_q;

  edge_sync u_cs (.core_clk(core_clk), .reset(reset), .pin(cs_pin), .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
  edge_sync u_clk (.core_clk(core_clk), .reset(reset), .pin(sclk_pin), .level(clk_lvl), .rise(clk_rise),
    .fall(clk_fall));
  edge_sync u_dat (.core_clk(core_clk), .reset(reset), .pin(serial_in_pin_in), .level(dat_lvl), .rise(dat_rise),
    .fall(dat_fall));

  // strap synchronised for the target id low bit
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sel_meta_q <= 1'b0;
      sel_q <= 1'b0;
    end
    else
    begin
      sel_meta_q <= serial_out_pin_in;
      sel_q <= sel_meta_q;
    end
  end
  assign sel_lvl = sel_q;

  logic i2c_mode;
  logic bus_open, bus_close;
  assign i2c_mode = cs_lvl;
  assign bus_open = i2c_mode & clk_lvl & dat_fall;
  assign bus_close = i2c_mode & clk_lvl & dat_rise;

  i2c_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [2:0] cnt_q, cnt_d;
  logic [3:0] spi_cnt_q, spi_cnt_d;
  logic first_q, first_d;
  logic dir_q, dir_d;
  logic inc_q, inc_d;
  logic [6:0] idx_q, idx_d;
  logic [7:0] tx_q, tx_d;
  logic sda_low_q, sda_low_d;
  logic so_q, so_d;
  logic so_en_q, so_en_d;
  logic busy_q, busy_d;
  logic [7:0] wdat_q, wdat_d;
  logic wstb_q, wstb_d;
  logic rstb_q, rstb_d;
  logic byte_done_q, byte_done_d;
  logic [7:0] nxt_sh;

  assign nxt_sh = {sh_q[6:0], dat_lvl};

  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    spi_cnt_d = spi_cnt_q;
    first_d = first_q;
    dir_d = dir_q;
    inc_d = inc_q;
    idx_d = idx_q;
    tx_d = tx_q;
    sda_low_d = sda_low_q;
    so_d = so_q;
    so_en_d = so_en_q;
    busy_d = busy_q;
    wdat_d = wdat_q;
    wstb_d = 1'b0;
    rstb_d = 1'b0;
    byte_done_d = byte_done_q;
    if (i2c_mode)
    begin
      so_en_d = 1'b0;
      spi_cnt_d = 4'h0;
      if (bus_open)
      begin
        // start or repeated start
        st_d = I2C_ADDR;
        cnt_d = 3'h0;
        byte_done_d = 1'b0;
        sda_low_d = 1'b0;
        busy_d = 1'b1;
      end
      else if (bus_close)
      begin
        st_d = I2C_IDLE;
        sda_low_d = 1'b0;
        busy_d = 1'b0;
      end
      else if (clk_rise)
      begin
        unique case (st_q)
          I2C_ADDR, I2C_INDEX, I2C_WRITE:
          begin
            sh_d = nxt_sh;
            cnt_d = cnt_q + 3'h1;
            // eighth bit in: the next fall completes the byte
            byte_done_d = (cnt_q == BIT_LAST);
          end
          I2C_RACK:
          begin
            // controller ack keeps reading, nack ends
            if (dat_lvl)
              st_d = I2C_IDLE;
          end
          default:
          begin
          end
        endcase
      end
      else if (clk_fall)
      begin
        byte_done_d = 1'b0;
        unique case (st_q)
          I2C_IDLE:
          begin
          end
          I2C_ADDR:
          begin
            if (byte_done_q)
            begin
              if (sh_q[7:1] == {TARGET_ID_HIGH, sel_lvl})
              begin
                dir_d = sh_q[0];
                sda_low_d = 1'b1;
                st_d = I2C_ADDR_ACK;
              end
              else
                st_d = I2C_IDLE;
            end
          end
          I2C_ADDR_ACK:
          begin
            if (dir_q)
            begin
              rstb_d = 1'b1;
              tx_d = reg_read_data;
              sda_low_d = ~reg_read_data[7];
              cnt_d = 3'h1;
              st_d = I2C_READ;
            end
            else
            begin
              sda_low_d = 1'b0;
              cnt_d = 3'h0;
              st_d = I2C_INDEX;
            end
          end
          I2C_INDEX:
          begin
            if (byte_done_q)
            begin
              idx_d = sh_q[6:0];
              inc_d = sh_q[7];
              sda_low_d = 1'b1;
              st_d = I2C_WACK;
            end
          end
          I2C_WRITE:
          begin
            if (byte_done_q)
            begin
              wdat_d = sh_q;
              wstb_d = 1'b1;
              sda_low_d = 1'b1;
              st_d = I2C_WACK;
            end
          end
          I2C_WACK:
          begin
            sda_low_d = 1'b0;
            cnt_d = 3'h0;
            st_d = I2C_WRITE;
            if (first_q && inc_q)
              idx_d = idx_q + 7'h01;
            first_d = 1'b1;
          end
          I2C_READ:
          begin
            if (cnt_q == 3'h0)
            begin
              sda_low_d = 1'b0;
              if (inc_q)
                idx_d = idx_q + 7'h01;
              st_d = I2C_RACK;
            end
            else
            begin
              sda_low_d = ~tx_q[BIT_LAST - cnt_q];
              cnt_d = cnt_q + 3'h1;
            end
          end
          I2C_RACK:
          begin
            rstb_d = 1'b1;
            tx_d = reg_read_data;
            sda_low_d = ~reg_read_data[7];
            cnt_d = 3'h1;
            st_d = I2C_READ;
          end
        endcase
      end
      if (bus_open && st_q == I2C_IDLE)
        first_d = 1'b0;
    end
    else
    begin
      // SPI: chip select low
      st_d = I2C_IDLE;
      sda_low_d = 1'b0;
      busy_d = ~cs_lvl;
      if (cs_fall)
      begin
        spi_cnt_d = 4'h0;
        first_d = 1'b0;
        so_en_d = 1'b0;
      end
      else if (clk_rise)
      begin
        sh_d = nxt_sh;
        if (spi_cnt_q == SPI_BIT_DIR)
          dir_d = dat_lvl;
        if (spi_cnt_q == SPI_BIT_INC)
          inc_d = dat_lvl;
        if (spi_cnt_q == SPI_DATA_START - 4'h1)
        begin
          idx_d = {1'b0, nxt_sh[5:0]};
        end
        if (spi_cnt_q == 4'hF)
        begin
          // block complete: whole byte only, so partial writes never land
          if (!dir_q)
          begin
            wdat_d = nxt_sh;
            wstb_d = 1'b1;
          end
          if (inc_q && dir_q)
            idx_d = idx_q + 7'h01;
          spi_cnt_d = SPI_DATA_START;
          first_d = 1'b1;
        end
        else
          spi_cnt_d = spi_cnt_q + 4'h1;
      end
      else if (clk_fall && spi_cnt_q >= SPI_DATA_START && dir_q)
      begin
        // each byte loads once the index has settled
        if (spi_cnt_q == SPI_DATA_START)
        begin
          rstb_d = 1'b1;
          tx_d = reg_read_data;
          so_d = reg_read_data[7];
        end
        else
          so_d = tx_q[BIT_LAST - spi_cnt_q[2:0]];
        so_en_d = 1'b1;
      end
      // write index steps after its strobe, so each byte lands where addressed
      if (wstb_q && inc_q)
        idx_d = idx_q + 7'h01;
    end
    if (cs_rise)
    begin
      spi_cnt_d = 4'h0;
      so_en_d = 1'b0;
      st_d = I2C_IDLE;
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_q <= I2C_IDLE;
      sh_q <= BYTE_RESET;
      cnt_q <= 3'h0;
      spi_cnt_q <= 4'h0;
      first_q <= 1'b0;
      dir_q <= 1'b0;
      inc_q <= 1'b0;
      idx_q <= INDEX_RESET;
      tx_q <= BYTE_RESET;
      sda_low_q <= 1'b0;
      so_q <= 1'b0;
      so_en_q <= 1'b0;
      busy_q <= 1'b0;
      wdat_q <= BYTE_RESET;
      wstb_q <= 1'b0;
      rstb_q <= 1'b0;
      byte_done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      spi_cnt_q <= spi_cnt_d;
      first_q <= first_d;
      dir_q <= dir_d;
      inc_q <= inc_d;
      idx_q <= idx_d;
      tx_q <= tx_d;
      sda_low_q <= sda_low_d;
      so_q <= so_d;
      so_en_q <= so_en_d;
      busy_q <= busy_d;
      wdat_q <= wdat_d;
      wstb_q <= wstb_d;
      rstb_q <= rstb_d;
      byte_done_q <= byte_done_d;
    end
  end

  // open-drain in I2C; three wire read drives the shared pin
  assign serial_in_pin_out = i2c_mode ? 1'b0 : so_q;
  assign serial_in_pin_oe = i2c_mode ? sda_low_q : (so_en_q & three_wire_select & ~cs_lvl);
  assign serial_out_pin_out = so_q;
  assign serial_out_pin_oe = so_en_q & ~three_wire_select & ~cs_lvl;
  assign reg_index = idx_q;
  assign reg_write_data = wdat_q;
  assign reg_write_strobe = wstb_q;
  assign reg_read_strobe = rstb_q;
  assign bus_busy = busy_q;
endmodule

/* port_chk.sv */
// concurrent checks on the dual serial register port
`timescale 1ns/1ps
module port_chk
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cs_pin,
  input wire logic sclk_pin,
  input wire logic serial_in_pin_in,
  input wire logic serial_in_pin_out,
  input wire logic serial_in_pin_oe,
  input wire logic serial_out_pin_in,
  input wire logic serial_out_pin_out,
  input wire logic serial_out_pin_oe,
  input wire logic three_wire_select,
  input wire logic [6:0] reg_index,
  input wire logic [7:0] reg_read_data,
  input wire logic [7:0] reg_write_data,
  input wire logic reg_write_strobe,
  input wire logic reg_read_strobe,
  input wire logic bus_busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  sequence s_i2c_mode;
    cs_pin && $past(cs_pin, 6);
  endsequence
  sequence s_spi_mode;
    !cs_pin && !$past(cs_pin, 6);
  endsequence
  sequence s_no_write;
    !reg_write_strobe [*8];
  endsequence
  property p_ack_low;
    s_i2c_mode and serial_in_pin_oe |-> !serial_in_pin_out;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("data pin driven high");
  property p_idle_quiet;
    !bus_busy && !$past(bus_busy) |-> !serial_in_pin_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("data pin driven when idle");
  property p_i2c_no_serial_out_pin;
    s_i2c_mode |-> !serial_out_pin_oe;
  endproperty
  a_i2c_no_serial_out_pin: assert property (p_i2c_no_serial_out_pin) else $error("strap pin driven");
  property p_spi_busy;
    s_spi_mode |-> bus_busy;
  endproperty
  a_spi_busy: assert property (p_spi_busy) else $error("busy low in frame");
  property p_three_wire;
    three_wire_select |-> !serial_out_pin_oe;
  endproperty
  a_three_wire: assert property (p_three_wire) else $error("output pin in three wire");
  property p_four_wire;
    s_spi_mode and !three_wire_select |-> !serial_in_pin_oe;
  endproperty
  a_four_wire: assert property (p_four_wire) else $error("input pin driven");
  property p_write_in_frame;
    reg_write_strobe |-> bus_busy;
  endproperty
  a_write_in_frame: assert property (p_write_in_frame) else $error("write outside frame");
  property p_write_gap;
    reg_write_strobe |=> s_no_write;
  endproperty
  a_write_gap: assert property (p_write_gap) else $error("writes too close");
endmodule
bind dual_serial_register_port port_chk chk_u (.core_clk, .reset, .cs_pin, .sclk_pin, .serial_in_pin_in, .serial_in_pin_out,
  .serial_in_pin_oe, .serial_out_pin_in, .serial_out_pin_out, .serial_out_pin_oe, .three_wire_select, .reg_index, .reg_read_data, .reg_write_data,
  .reg_write_strobe, .reg_read_strobe, .bus_busy);

/* host_model.sv */
// host controller model for the shared serial pads
`timescale 1ns/1ps
module host_model
(
  input wire logic core_clk,
  input wire logic strap,
  input wire logic serial_in_pin_out,
  input wire logic serial_in_pin_oe,
  input wire logic serial_out_pin_out,
  input wire logic serial_out_pin_oe,
  output logic cs_pin,
  output logic sclk_pin,
  output logic serial_in_pin_in,
  output logic serial_out_pin_in
);
  logic sda_h = 1'b1;
  // pull-up unless someone pulls low
  assign serial_in_pin_in = serial_in_pin_oe ? (serial_in_pin_out & sda_h) : sda_h;
  assign serial_out_pin_in = serial_out_pin_oe ? serial_out_pin_out : strap;
  initial
  begin
    cs_pin = 1'b1;
    sclk_pin = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic i2c_open();
    sda_h = 1'b1;
    tick(5);
    sclk_pin = 1'b1;
    tick(4);
    sda_h = 1'b0;
    tick(4);
    sclk_pin = 1'b0;
  endtask
  task automatic i2c_close();
    sda_h = 1'b0;
    tick(5);
    sclk_pin = 1'b1;
    tick(4);
    sda_h = 1'b1;
    tick(8);
  endtask
  // nine clocks: a released bit reads the other side
  task automatic i2c_bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_h = tx[i];
      tick(4);
      sclk_pin = 1'b1;
      tick(3);
      rx[i] = serial_in_pin_in;
      sclk_pin = 1'b0;
      tick(1);
    end
  endtask
  task automatic spi_xfer(input logic [23:0] tx, input int n, input logic tw, output logic [23:0] rx);
    rx = 24'h000000;
    cs_pin = 1'b0;
    tick(4);
    for (int k = 0; k < n; k++)
    begin
      sclk_pin = 1'b0;
      tick(1);
      sda_h = (tw && k >= 8) ? 1'b1 : tx[23-k];
      tick(4);
      rx[23-k] = tw ? serial_in_pin_in : serial_out_pin_in;
      sclk_pin = 1'b1;
      tick(3);
    end
    tick(2);
    cs_pin = 1'b1;
    sda_h = 1'b1;
    tick(8);
  endtask
endmodule

/* testbench.sv */
// self-checking bench for the dual serial register port
`timescale 1ns/1ps
module testbench;
  logic core_clk, reset, cs_pin, sclk_pin, serial_in_pin_in, serial_in_pin_out, serial_in_pin_oe, serial_out_pin_in, serial_out_pin_out, serial_out_pin_oe, strap;
  logic three_wire_select, reg_write_strobe, reg_read_strobe, bus_busy;
  logic [6:0] reg_index;
  logic [7:0] reg_read_data, reg_write_data;
  logic [15:0] wlog[$];
  int failures = 0;
  int tests_run = 0;
  int rd_count = 0;
  dual_serial_register_port dut_u (.core_clk, .reset, .cs_pin, .sclk_pin, .serial_in_pin_in, .serial_in_pin_out, .serial_in_pin_oe,
    .serial_out_pin_in, .serial_out_pin_out, .serial_out_pin_oe, .three_wire_select, .reg_index, .reg_read_data, .reg_write_data,
    .reg_write_strobe, .reg_read_strobe, .bus_busy);
  host_model host_u (.core_clk, .strap, .serial_in_pin_out, .serial_in_pin_oe, .serial_out_pin_out, .serial_out_pin_oe, .cs_pin, .sclk_pin,
    .serial_in_pin_in, .serial_out_pin_in);
  function automatic logic [7:0] rd_val(input logic [6:0] i);
    return {i, 1'b0} ^ 8'hA5;
  endfunction
  assign reg_read_data = rd_val(reg_index);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (reg_write_strobe === 1'b1)
      wlog.push_back({1'b0, reg_index, reg_write_data});
    if (reg_read_strobe === 1'b1)
      rd_count++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_wr(input logic [15:0] e);
    check(wlog.size() > 0 ? wlog.pop_front() : 16'hFFFF, e);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic i2c_write_test();
    logic [8:0] rx;
    strap = 1'b1;
    host_u.i2c_open();
    host_u.i2c_bits({7'h5D, 1'b0, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    check(16'(bus_busy), 16'h0001);
    host_u.i2c_bits({8'h90, 1'b1}, rx);
    host_u.i2c_bits({8'hA5, 1'b1}, rx);
    host_u.i2c_bits({8'h3C, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    host_u.i2c_close();
    check(16'(bus_busy), 16'h0000);
    check_wr(16'h10A5);
    check_wr(16'h113C);
  endtask
  task automatic i2c_read_test();
    logic [8:0] rx;
    logic [8:0] d0;
    strap = 1'b0;
    host_u.i2c_open();
    host_u.i2c_bits({7'h5C, 1'b0, 1'b1}, rx);
    host_u.i2c_bits({8'h85, 1'b1}, rx);
    host_u.i2c_open();
    host_u.i2c_bits({7'h5C, 1'b1, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
    host_u.i2c_bits({8'hFF, 1'b0}, d0);
    host_u.i2c_bits({8'hFF, 1'b1}, rx);
    host_u.i2c_close();
    check({d0[8:1], rx[8:1]}, {rd_val(7'h05), rd_val(7'h06)});
    check(16'(rd_count), 16'h0002);
    host_u.i2c_open();
    host_u.i2c_bits({7'h5D, 1'b0, 1'b1}, rx);
    check(16'(rx[0]), 16'h0001);
    host_u.i2c_bits({8'h77, 1'b1}, rx);
    host_u.i2c_close();
    check(16'(wlog.size()), 16'h0000);
  endtask
  task automatic spi_test();
    logic [23:0] rx;
    host_u.spi_xfer({2'b01, 6'h0A, 16'h1122}, 24, 1'b0, rx);
    check_wr(16'h0A11);
    check_wr(16'h0B22);
    host_u.spi_xfer({2'b00, 6'h3F, 16'h5566}, 20, 1'b0, rx);
    check_wr(16'h3F55);
    check(16'(wlog.size()), 16'h0000);
    host_u.spi_xfer({2'b10, 6'h03, 16'h0000}, 24, 1'b0, rx);
    check(rx[15:0], {rd_val(7'h03), rd_val(7'h03)});
    check(16'(rd_count), 16'h0004);
    three_wire_select = 1'b1;
    host_u.spi_xfer({2'b11, 6'h07, 16'h0000}, 24, 1'b1, rx);
    check(rx[15:0], {rd_val(7'h07), rd_val(7'h08)});
    check(16'(rd_count), 16'h0006);
    three_wire_select = 1'b0;
  endtask
  initial
  begin
    reset = 1'b1;
    three_wire_select = 1'b0;
    strap = 1'b1;
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    i2c_write_test();
    i2c_read_test();
    spi_test();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end
endmodule
